// >>> logic/sac_consts.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
`define SAC_OFF_CTRL_A 8'h1F
`define SAC_OFF_CTRL_B 8'h9F
`define SAC_OFF_RES_HI 8'h1E
`define SAC_OFF_RES_LO 8'h9E
`define SAC_OFF_DONE 8'h0C
`define SAC_DONE_BIT 6
`define SAC_CLK_SEL_HI 7
`define SAC_CLK_SEL_LO 6
`define SAC_CHAN_HI 5
`define SAC_CHAN_LO 3
`define SAC_GO_BIT 2
`define SAC_ON_BIT 0
`define SAC_JUSTIFY_BIT 7
`define SAC_PCFG_HI 3
`define SAC_PCFG_LO 0
`define SAC_CTRL_A_MASK 8'hFD
`define SAC_CTRL_B_MASK 8'h8F
`define SAC_RESET_BYTE 8'h00
`define SAC_DIV_2 6'h01
`define SAC_DIV_8 6'h07
`define SAC_DIV_32 6'h1F
`define SAC_CONV_BITS 4'hA
`define SAC_SETTLE_PERIODS 4'h2
`define SAC_GAP_PERIODS 4'h2
`define SAC_MSB_MASK 10'h200
`define SAC_CMP_LATENCY 4'h2
`endif

// >>> logic/sac_pkg.sv
// types of the converter control: state enum and carrier structs
package sac_pkg;
    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_SETTLE,
        SAC_CONVERT,
        SAC_GAP
    } sac_state_e;

    // register-side request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sac_bus_s;

    // analog front end controls
    typedef struct packed {
        logic [2:0] channel;
        logic sample;
        logic powered;
        logic [9:0] trial;
        logic vref_pos_pin;
        logic vref_neg_pin;
        logic [7:0] analog_pins;
    } sac_afe_s;

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        logic done_flag;
        sac_state_e state;
        logic [5:0] div_cnt;
        logic rc_sync1;
        logic rc_sync2;
        logic rc_prev;
        logic [3:0] period_cnt;
        logic [9:0] trial;
        logic [9:0] mask;
        logic cmp_sync1;
        logic cmp_sync2;
        logic [7:0] rdata;
    } sac_state_s;
endpackage

// >>> logic/sac_adc_control.sv
// successive-approximation converter control with register file and front end drive
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "sac_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - clock select: osc/2, /8, /32, RC
// - channel field routes one input to hold
// - completion loads result, clears go, sets done
// - converter off shuts module down
// - right justify zeros high six bits
// - left justify zeros low six bits
// - unimplemented control bits read zero
// - port field sets analog or digital pins
// - reference codes use input 3, maybe 2
// - small package has only five inputs
// - two bit periods between conversions
// - sleep conversion only on RC clock
// - conversion lasts at least twelve bit periods
// - clearing go aborts, result untouched
// - unused result bits load zero
module sac_adc_control #(
    parameter bit LARGE_PACKAGE = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port
    input wire sac_pkg::sac_bus_s bus_i,
    output logic [7:0] rdata_o,
    // analog front end
    input wire logic rc_clk_i,
    input wire logic comparator_i,
    input wire logic sleep_i,
    output sac_pkg::sac_afe_s afe_o,
    // completion event to the interrupt controller
    output logic done_flag_o
);
    import sac_pkg::*;

    sac_state_s cur_reg;
    sac_state_s cur_next;
    logic tick;
    logic go_set;
    logic go_clr;
    logic [15:0] packed_res;
    logic [7:0] pins;
    logic [3:0] pcfg;

    ////////////////////////////////////////////////////////////////////////////
    // port configuration decode, used for both pin map and reference choice
    function automatic logic [7:0] analog_map(input logic [3:0] code);
        case (code)
            4'h0: analog_map = 8'hFF;
            4'h1: analog_map = 8'hF7;
            4'h2: analog_map = 8'h1F;
            4'h3: analog_map = 8'h17;
            4'h4: analog_map = 8'h0B;
            4'h5: analog_map = 8'h03;
            4'h8: analog_map = 8'hF3;
            4'h9: analog_map = 8'h3F;
            4'hA: analog_map = 8'h37;
            4'hB: analog_map = 8'h33;
            4'hC: analog_map = 8'h13;
            4'hD: analog_map = 8'h03;
            4'hE: analog_map = 8'h01;
            4'hF: analog_map = 8'h01;
            default: analog_map = 8'h00;
        endcase
    endfunction

    function automatic logic uses_vref_pos(input logic [3:0] code);
        case (code)
            4'h1, 4'h3, 4'h5, 4'h8, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF: uses_vref_pos = 1'b1;
            default: uses_vref_pos = 1'b0;
        endcase
    endfunction

    function automatic logic uses_vref_neg(input logic [3:0] code);
        case (code)
            4'h8, 4'hB, 4'hC, 4'hD, 4'hF: uses_vref_neg = 1'b1;
            default: uses_vref_neg = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // front end drive and pin map
    assign pcfg = cur_reg.ctrl_b[`SAC_PCFG_HI:`SAC_PCFG_LO];
    assign pins = LARGE_PACKAGE ? analog_map(pcfg) : (analog_map(pcfg) & 8'h1F);
    always_comb begin
        afe_o.channel = cur_reg.ctrl_a[`SAC_CHAN_HI:`SAC_CHAN_LO];
        afe_o.powered = cur_reg.ctrl_a[`SAC_ON_BIT];
        // holding cap connected only while idle and powered; gap keeps it off
        afe_o.sample = cur_reg.ctrl_a[`SAC_ON_BIT] && (cur_reg.state == SAC_IDLE);
        afe_o.trial = cur_reg.trial;
        afe_o.vref_pos_pin = uses_vref_pos(pcfg);
        afe_o.vref_neg_pin = uses_vref_neg(pcfg);
        afe_o.analog_pins = pins & ~{4'h0, afe_o.vref_pos_pin, afe_o.vref_neg_pin, 2'h0};
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit period tick from divided core clock or synced RC clock edge
    always_comb begin
        case (cur_reg.ctrl_a[`SAC_CLK_SEL_HI:`SAC_CLK_SEL_LO])
            2'h0: tick = ((cur_reg.div_cnt & `SAC_DIV_2) == `SAC_DIV_2);
            2'h1: tick = ((cur_reg.div_cnt & `SAC_DIV_8) == `SAC_DIV_8);
            2'h2: tick = ((cur_reg.div_cnt & `SAC_DIV_32) == `SAC_DIV_32);
            // RC clock keeps ticking in sleep
            default: tick = cur_reg.rc_sync2 && !cur_reg.rc_prev;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // software side of the go flag
    assign go_set = bus_i.wr && (bus_i.addr == `SAC_OFF_CTRL_A) && bus_i.wdata[`SAC_GO_BIT]
                    && cur_reg.ctrl_a[`SAC_ON_BIT];
    assign go_clr = bus_i.wr && (bus_i.addr == `SAC_OFF_CTRL_A) && !bus_i.wdata[`SAC_GO_BIT];

    assign packed_res = cur_reg.ctrl_b[`SAC_JUSTIFY_BIT] ? {6'h00, cur_reg.trial} :
                        {cur_reg.trial, 6'h00};

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        cur_next = cur_reg;
        cur_next.div_cnt = 6'(cur_reg.div_cnt + 6'h01);
        // rc clock crosses two flops before the edge detect
        cur_next.rc_sync1 = rc_clk_i;
        cur_next.rc_sync2 = cur_reg.rc_sync1;
        cur_next.rc_prev = cur_reg.rc_sync2;
        cur_next.cmp_sync1 = comparator_i;
        cur_next.cmp_sync2 = cur_reg.cmp_sync1;
        cur_next.rdata = `SAC_RESET_BYTE;

        // register writes; go bit handled by the sequencer below
        if (bus_i.wr) begin
            case (bus_i.addr)
                `SAC_OFF_CTRL_A: begin
                    cur_next.ctrl_a = (bus_i.wdata & `SAC_CTRL_A_MASK & ~8'h04) |
                                      (cur_reg.ctrl_a & 8'h04);
                end
                `SAC_OFF_CTRL_B: cur_next.ctrl_b = bus_i.wdata & `SAC_CTRL_B_MASK;
                `SAC_OFF_RES_HI: cur_next.res_hi = bus_i.wdata;
                `SAC_OFF_RES_LO: cur_next.res_lo = bus_i.wdata;
                `SAC_OFF_DONE: cur_next.done_flag = bus_i.wdata[`SAC_DONE_BIT];
                default: ;
            endcase
        end

        // go flag reads one while converting
        if (go_set) begin
            cur_next.ctrl_a[`SAC_GO_BIT] = 1'b1;
        end
        // clear of go aborts without result update
        if (go_clr) begin
            cur_next.ctrl_a[`SAC_GO_BIT] = 1'b0;
        end

        case (cur_reg.state)
            SAC_IDLE: begin
                if (cur_reg.ctrl_a[`SAC_GO_BIT]) begin
                    cur_next.state = SAC_SETTLE;
                    cur_next.period_cnt = 4'h0;
                end
            end
            SAC_SETTLE: begin
                if (tick) begin
                    cur_next.period_cnt = 4'(cur_reg.period_cnt + 4'h1);
                    if (cur_reg.period_cnt == `SAC_SETTLE_PERIODS - 4'h1) begin
                        cur_next.state = SAC_CONVERT;
                        cur_next.period_cnt = 4'h0;
                        cur_next.trial = `SAC_MSB_MASK;
                        cur_next.mask = `SAC_MSB_MASK;
                    end
                end
            end
            SAC_CONVERT: begin
                // comparator answer lags the trial by two sync flops; a fast
                // clock stretches the bit period rather than use a stale answer
                if (cur_reg.period_cnt != `SAC_CMP_LATENCY) begin
                    cur_next.period_cnt = 4'(cur_reg.period_cnt + 4'h1);
                end
                // keep or drop trial bit, msb first
                if (tick && cur_reg.period_cnt == `SAC_CMP_LATENCY) begin
                    cur_next.period_cnt = 4'h0;
                    cur_next.trial = (cur_reg.cmp_sync2 ? cur_reg.trial : cur_reg.trial
                                     & ~cur_reg.mask) | (cur_reg.mask >> 1);
                    cur_next.mask = cur_reg.mask >> 1;
                    if (cur_reg.mask == 10'h001) begin
                        // two settle plus ten bit periods gives twelve
                        // clear go and set done here; the result loads one cycle later, on the first gap cycle
                        cur_next.trial = cur_reg.cmp_sync2 ? cur_reg.trial :
                                         cur_reg.trial & ~cur_reg.mask;
                        cur_next.state = SAC_GAP;
                        cur_next.period_cnt = 4'h0;
                        cur_next.ctrl_a[`SAC_GO_BIT] = 1'b0;
                        cur_next.done_flag = 1'b1;
                    end
                end
            end
            SAC_GAP: begin
                // hold off acquisition for two bit periods
                if (tick) begin
                    cur_next.period_cnt = 4'(cur_reg.period_cnt + 4'h1);
                    if (cur_reg.period_cnt == `SAC_GAP_PERIODS - 4'h1) begin
                        cur_next.state = SAC_IDLE;
                    end
                end
            end
            default: cur_next.state = SAC_IDLE;
        endcase

        // abort paths: go cleared, module off, or sleep on a core-derived clock
        if ((cur_reg.state == SAC_SETTLE || cur_reg.state == SAC_CONVERT) &&
            (go_clr || !cur_reg.ctrl_a[`SAC_ON_BIT] ||
             (sleep_i && cur_reg.ctrl_a[`SAC_CLK_SEL_HI:`SAC_CLK_SEL_LO] != 2'h3))) begin
            cur_next.state = SAC_GAP;
            cur_next.period_cnt = 4'h0;
            cur_next.ctrl_a[`SAC_GO_BIT] = 1'b0;
        end
        // module off stops everything at once
        if (!cur_reg.ctrl_a[`SAC_ON_BIT]) begin
            cur_next.state = SAC_IDLE;
            cur_next.ctrl_a[`SAC_GO_BIT] = 1'b0;
        end

        // result commit on completion outranks a same-cycle software write
        if (cur_reg.state == SAC_GAP && cur_reg.period_cnt == 4'h0 && cur_reg.done_flag &&
            cur_reg.mask == 10'h000) begin
            cur_next.res_hi = packed_res[15:8];
            cur_next.res_lo = packed_res[7:0];
            cur_next.mask = 10'h3FF;
        end

        // reads answer one cycle later
        if (bus_i.rd) begin
            case (bus_i.addr)
                `SAC_OFF_CTRL_A: cur_next.rdata = cur_reg.ctrl_a;
                `SAC_OFF_CTRL_B: cur_next.rdata = cur_reg.ctrl_b;
                `SAC_OFF_RES_HI: cur_next.rdata = cur_reg.res_hi;
                `SAC_OFF_RES_LO: cur_next.rdata = cur_reg.res_lo;
                `SAC_OFF_DONE: cur_next.rdata = {1'b0, cur_reg.done_flag, 6'h00};
                default: cur_next.rdata = `SAC_RESET_BYTE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign rdata_o = cur_reg.rdata;
    assign done_flag_o = cur_reg.done_flag;
endmodule

// >>> sim/sac_afe_model.sv
// behavioural front end: comparator on a held level and a free rc clock
`timescale 1ns/1ps
module sac_afe_model
    import sac_pkg::*;
#(
    parameter int RC_HALF_NS = 1000
) (
    // controls from the block and the test level
    input wire sac_pkg::sac_afe_s afe_i,
    input wire logic [9:0] level_i,
    // answers to the block
    output logic rc_clk_o,
    output logic comparator_o
);
    logic [9:0] held;
    initial begin
        rc_clk_o = 1'b0;
        forever #(RC_HALF_NS) rc_clk_o = ~rc_clk_o;
    end
    // analog pins are only sensed here, never driven, as inputs
    // each channel sees its own level
    assign held = level_i ^ {7'h00, afe_i.channel};
    // compare against trial code
    // unpowered, the answer wanders so a stale value cannot pass
    assign comparator_o = afe_i.powered ? (held >= afe_i.trial) : rc_clk_o;
endmodule

// >>> sim/sac_adc_control_assertions.sv
// port-level checker of the converter control
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_adc_control_assertions
    import sac_pkg::*;
#(
    parameter bit LARGE_PACKAGE = 1'b1
) (
    // clock, reset and register port
    input wire logic clk_i,
    input wire logic reset_i,
    input wire sac_pkg::sac_bus_s bus_i,
    input wire logic [7:0] rdata_o,
    // front end and event
    input wire sac_pkg::sac_afe_s afe_o,
    input wire logic done_flag_o
);
    logic wa;
    logic [3:0] port_cfg_reg;
    // write to control a at the port
    assign wa = bus_i.wr && bus_i.addr == `SAC_OFF_CTRL_A;
    // shadow of the port field so digital codes can be judged
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            port_cfg_reg <= 4'h0;
        end else if (bus_i.wr && bus_i.addr == `SAC_OFF_CTRL_B) begin
            port_cfg_reg <= bus_i.wdata[3:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_gap_a;
        $past(bus_i.rd) && $past(bus_i.addr) == `SAC_OFF_CTRL_A |-> !rdata_o[1];
    endproperty
    a_gap_a: assert property (p_gap_a) else $error("control a bit 1 set");
    property p_gap_b;
        $past(bus_i.rd) && $past(bus_i.addr) == `SAC_OFF_CTRL_B |-> rdata_o[6:4] == 3'h0;
    endproperty
    a_gap_b: assert property (p_gap_b) else $error("control b gap set");
    property p_chan;
        wa |=> afe_o.channel == $past(bus_i.wdata[5:3]);
    endproperty
    a_chan: assert property (p_chan) else $error("channel not routed");
    property p_on;
        wa |=> afe_o.powered == $past(bus_i.wdata[0]);
    endproperty
    a_on: assert property (p_on) else $error("power not following");
    property p_off;
        !afe_o.powered |-> !afe_o.sample;
    endproperty
    a_off: assert property (p_off) else $error("sampling while off");
    property p_ref;
        afe_o.vref_pos_pin |->
            !afe_o.analog_pins[3] && !(afe_o.vref_neg_pin && afe_o.analog_pins[2]);
    endproperty
    a_ref: assert property (p_ref) else $error("reference pin also analog");
    property p_neg;
        afe_o.vref_neg_pin |-> afe_o.vref_pos_pin;
    endproperty
    a_neg: assert property (p_neg) else $error("negative ref alone");
    property p_dig;
        port_cfg_reg[3:1] == 3'h3 |-> afe_o.analog_pins == 8'h00;
    endproperty
    a_dig: assert property (p_dig) else $error("pins analog in digital code");
    property p_sticky;
        done_flag_o && !(bus_i.wr && bus_i.addr == `SAC_OFF_DONE) |=> done_flag_o;
    endproperty
    a_sticky: assert property (p_sticky) else $error("done flag dropped");
    c_done: cover property ($rose(done_flag_o));
    c_neg: cover property (afe_o.vref_neg_pin);
    c_dig: cover property (port_cfg_reg[3:1] == 3'h3);
endmodule
bind sac_adc_control sac_adc_control_assertions #(.LARGE_PACKAGE(LARGE_PACKAGE)) sac_adc_control_assertions_i (
    .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .afe_o(afe_o), .done_flag_o(done_flag_o));

// >>> sim/sac_adc_control_tb.sv
// self-checking bench of the converter control
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_adc_control_tb;
    import sac_pkg::*;
    logic clk_i;
    logic reset_i;
    logic sleep_i;
    logic rc_clk;
    logic cmp;
    logic [9:0] level;
    logic [9:0] ev;
    logic [7:0] rdata_o;
    logic [7:0] ctl;
    logic [15:0] res;
    logic done_flag_o;
    sac_bus_s bus;
    sac_afe_s afe;
    int error_cnt;
    int comparisons;
    int n;
    int per[4] = '{2, 8, 32, 40};
    logic [9:0] vins[4] = '{10'h2B5, 10'h3FF, 10'h000, 10'h155};
    logic [7:0] adr[6] = '{8'h1F, 8'h9F, 8'h1E, 8'h9E, 8'h0C, 8'h55};
    // {code, analog pins, pos ref, neg ref}
    logic [13:0] cfg[7] = '{14'h03FC, 14'h07DE, 14'h1800, 14'h23CF, 14'h3804, 14'h3C07, 14'h102C};
    sac_adc_control #(.LARGE_PACKAGE(1'b1)) sac_adc_control_i (
        .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata_o),
        .rc_clk_i(rc_clk), .comparator_i(cmp), .sleep_i(sleep_i),
        .afe_o(afe), .done_flag_o(done_flag_o));
    sac_afe_model sac_afe_model_i (
        .afe_i(afe), .level_i(level), .rc_clk_o(rc_clk), .comparator_o(cmp));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        comparisons++;
        if (got !== want) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic bw(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= v;
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk_i);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1;
        chk({8'h00, rdata_o & m}, {8'h00, e});
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wait_done(output int c);
        c = 0;
        while (done_flag_o !== 1'b1) begin
            @(posedge clk_i);
            c++;
            if (c > 20000) begin
                error_cnt++;
                wrap_up();
            end
        end
    endtask
    initial begin
        reset_i = 1'b1;
        sleep_i = 1'b0;
        bus = '0;
        level = 10'h000;
        error_cnt = 0;
        comparisons = 0;
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        foreach (adr[i]) rc(adr[i], 8'hFF, 8'h00);
        bw(`SAC_OFF_CTRL_B, 8'hFF);
        rc(`SAC_OFF_CTRL_B, 8'hFF, 8'h8F);
        bw(`SAC_OFF_CTRL_A, 8'hFE);
        rc(`SAC_OFF_CTRL_A, 8'hFF, 8'hF8);
        bw(`SAC_OFF_RES_HI, 8'h12);
        rc(`SAC_OFF_RES_HI, 8'hFF, 8'h12);
        foreach (cfg[i]) begin
            bw(`SAC_OFF_CTRL_B, {4'h0, cfg[i][13:10]});
            #1;
            chk({afe.analog_pins, 6'h00, afe.vref_pos_pin, afe.vref_neg_pin}, {cfg[i][9:2], 6'h00, cfg[i][1:0]});
        end
        // every clock code, alternating justification, sleeping on rc
        for (int k = 0; k < 4; k++) begin
            level <= vins[k];
            ctl = {2'(k), 3'(k + 4), 3'h1};
            sleep_i <= (k == 3);
            bw(`SAC_OFF_CTRL_B, {!k[0], 7'h00});
            bw(`SAC_OFF_CTRL_A, ctl);
            repeat (20) @(posedge clk_i);
            bw(`SAC_OFF_DONE, 8'h00);
            bw(`SAC_OFF_CTRL_A, ctl | 8'h04);
            chk(16'(afe.channel), 16'(k + 4));
            wait_done(n);
            chk(16'(n >= 11 * per[k]), 16'h0001);
            repeat (2) @(posedge clk_i);
            ev = vins[k] ^ 10'(k + 4);
            res = k[0] ? {ev, 6'h00} : {6'h00, ev};
            rc(`SAC_OFF_CTRL_A, 8'hFF, ctl);
            rc(`SAC_OFF_RES_HI, 8'hFF, res[15:8]);
            rc(`SAC_OFF_RES_LO, 8'hFF, res[7:0]);
            rc(`SAC_OFF_DONE, 8'h40, 8'h40);
        end
        // abort by clearing go, then by sleep on a core-derived clock
        sleep_i <= 1'b0;
        level <= 10'h0F0;
        for (int m = 0; m < 2; m++) begin
            ctl = 8'h89 - 8'(m * 64);
            // let the previous gap run out so the abort hits a live conversion
            repeat (100) @(posedge clk_i);
            bw(`SAC_OFF_DONE, 8'h00);
            bw(`SAC_OFF_CTRL_A, ctl | 8'h04);
            repeat (40) @(posedge clk_i);
            if (m == 0) bw(`SAC_OFF_CTRL_A, ctl);
            else sleep_i <= 1'b1;
            repeat (600) @(posedge clk_i);
            sleep_i <= 1'b0;
            bw(`SAC_OFF_CTRL_A, ctl);
            chk(16'(done_flag_o), 16'h0000);
            rc(`SAC_OFF_RES_HI, 8'hFF, res[15:8]);
            rc(`SAC_OFF_RES_LO, 8'hFF, res[7:0]);
        end
        wrap_up();
    end
endmodule
